// ==== common/addr_map_pkg.sv ====
//Function
//- Every logical address is decoded as a 32-bit value in one linear 4-Gbyte space.
//- User space is 0x0000_0000 to 0x7FFF_FFFF and holds ROM, external, RAM and peripherals.
//- System space 0x8000_0000 to 0xFFFF_FFFF is kept for debug tools, never for users.
//- Three mode pins pick single-chip, extension, processor (flash pin low) or reserved mode.
//- The low 8 Mbytes hold ROM and external regions placed by mode; all other regions are fixed.
//- ROM holds exception_vector_entry at zero and ends at 0x7FFFF, 0x5FFFF or 0x3FFFF.
//- External regions exist only in extension or processor mode, never in single-chip mode.
//- Access to the first region drives low_region_select_n, the second high_region_select_n.
//- Extension mode: first 0x100000-0x1FFFFF, second 0x200000-0x2FFFFF with ghost to 0x3FFFFF.
//- Processor mode: first 0x0-0xFFFFF with ghost to 0x1FFFFF, second as in extension mode.
//- 0x800000-0xFFFFFF repeats its first 128 Kbytes of RAM and peripherals as ghosts.
//- Internal RAM is 24 Kbytes at 0x804000-0x809FFF for every size variant.
//- The peripheral_register_window spans 0x800000-0x803FFF below the RAM.
package addr_map_pkg;

	// ----------------------------------------
	// Address layout
	// ----------------------------------------
	localparam int          ADDR_W      = 32;
	localparam int          ROM_KB_DEF  = 512;
	localparam logic [8:0]  LOW8M_TAG   = 9'h000;
	localparam logic [8:0]  HIGH8M_TAG  = 9'h001;
	localparam int          WIN_W       = 17;
	localparam int          CMP_W       = 23;
	localparam logic [22:0] PERIPH_LO   = 23'h000000;
	localparam logic [22:0] PERIPH_HI   = 23'h003FFF;
	localparam logic [22:0] RAM_LO      = 23'h004000;
	localparam logic [22:0] RAM_HI      = 23'h009FFF;
	localparam logic [2:0]  CS0_EXT_MB  = 3'h1;
	localparam logic [1:0]  CS0_PROC_2M = 2'h0;
	localparam logic [1:0]  CS1_2M      = 2'h1;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		MODE_SINGLE   = 4'b0001,
		MODE_EXTEND   = 4'b0010,
		MODE_PROC     = 4'b0100,
		MODE_RESERVED = 4'b1000
	} op_mode_type;

	typedef struct packed {
		logic system_space;
		logic rom;
		logic first_ext;
		logic second_ext;
		logic ram;
		logic periph;
		logic unmapped;
	} region_hits_type;

	localparam region_hits_type HITS_NONE = '0;

endpackage

// ==== sim/ext_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module ext_mem_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Chip selects
	input  wire logic low_region_select_n,
	input  wire logic high_region_select_n,
	// Access counts
	output var int    low_count,
	output var int    high_count
);
	// Counts cycles in which each device is selected
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_count  <= 0;
			high_count <= 0;
		end else begin
			low_count  <= low_count + int'(!low_region_select_n);
			high_count <= high_count + int'(!high_region_select_n);
		end
	end
endmodule // ext_mem_model

`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
	$display("CHECK FAILED %0t %s", $time, msg); end end

module tb;
	typedef struct packed {
		logic [3:0]  straps;
		logic [31:0] addr;
		logic [6:0]  hits;
	} vec_type;

	logic                          clk                  = 1'b0;
	logic                          rst_n                = 1'b0;
	logic                          mode_select_first    = 1'b0;
	logic                          mode_select_second   = 1'b0;
	logic                          mode_select_third    = 1'b0;
	logic                          flash_program_pin    = 1'b0;
	logic                          access_valid         = 1'b0;
	logic [31:0]                   addr                 = 32'h0;
	logic                          decode_valid;
	addr_map_pkg::region_hits_type hits;
	logic                          low_region_select_n;
	logic                          high_region_select_n;
	logic                          mode_valid;
	addr_map_pkg::op_mode_type     op_mode;
	int                            low_count;
	int                            high_count;
	int                            err_count            = 0;
	int                            checks_done          = 0;
	int                            exp_lo               = 0;
	int                            exp_hi               = 0;

	// Straps {flash, third, second, first}, address, expected hits
	vec_type vecs [0:30] = '{
		'{4'h0, 32'h0000_0000, 7'h20}, '{4'h0, 32'h0007_FFFF, 7'h20},
		'{4'h0, 32'h0008_0000, 7'h01}, '{4'h0, 32'h0010_0000, 7'h01},
		'{4'h0, 32'h0080_0000, 7'h02}, '{4'h0, 32'h0080_3FFF, 7'h02},
		'{4'h0, 32'h0080_4000, 7'h04}, '{4'h0, 32'h0080_9FFF, 7'h04},
		'{4'h0, 32'h0080_A000, 7'h01}, '{4'h0, 32'h0082_4000, 7'h04},
		'{4'h0, 32'h00FF_FFFF, 7'h01}, '{4'h0, 32'h0100_0000, 7'h01},
		'{4'h0, 32'h7FFF_FFFF, 7'h01}, '{4'h0, 32'h8000_0000, 7'h40},
		'{4'h0, 32'hFFFF_FFFF, 7'h40}, '{4'h2, 32'h0000_0000, 7'h20},
		'{4'h2, 32'h000F_FFFF, 7'h01}, '{4'h2, 32'h0010_0000, 7'h10},
		'{4'h2, 32'h001F_FFFF, 7'h10}, '{4'h2, 32'h0020_0000, 7'h08},
		'{4'h2, 32'h003F_FFFF, 7'h08}, '{4'h2, 32'h0040_0000, 7'h01},
		'{4'h2, 32'h0080_4000, 7'h04}, '{4'h1, 32'h0000_0000, 7'h10},
		'{4'h1, 32'h001F_FFFF, 7'h10}, '{4'h1, 32'h0020_0000, 7'h08},
		'{4'h1, 32'h0030_0000, 7'h08}, '{4'h1, 32'h0040_0000, 7'h01},
		'{4'h3, 32'h0010_0000, 7'h01}, '{4'h4, 32'h0020_0000, 7'h01},
		'{4'h9, 32'h0000_0000, 7'h01}
	};

	address_map_decoder #(.ROM_KB(512)) i_dut (
		.clk(clk), .rst_n(rst_n), .mode_select_first(mode_select_first),
		.mode_select_second(mode_select_second), .mode_select_third(mode_select_third),
		.flash_program_pin(flash_program_pin), .access_valid(access_valid), .addr(addr),
		.decode_valid(decode_valid), .hits(hits), .low_region_select_n(low_region_select_n),
		.high_region_select_n(high_region_select_n), .mode_valid(mode_valid), .op_mode(op_mode)
	);

	ext_mem_model i_mem (
		.clk(clk), .rst_n(rst_n), .low_region_select_n(low_region_select_n),
		.high_region_select_n(high_region_select_n), .low_count(low_count),
		.high_count(high_count)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic addr_map_pkg::op_mode_type exp_mode(input logic [3:0] s);
		case (s)
			4'h0: return addr_map_pkg::MODE_SINGLE;
			4'h2: return addr_map_pkg::MODE_EXTEND;
			4'h1: return addr_map_pkg::MODE_PROC;
			default: return addr_map_pkg::MODE_RESERVED;
		endcase
	endfunction

	task automatic wrap_up();
		if (err_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic do_reset(input logic [3:0] s);
		`CHK(low_count, exp_lo, "low count")
		`CHK(high_count, exp_hi, "high count")
		exp_lo = 0;
		exp_hi = 0;
		@(posedge clk);
		rst_n <= 1'b0;
		{flash_program_pin, mode_select_third, mode_select_second, mode_select_first} <= s;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		// Strap changes after release must be ignored
		{flash_program_pin, mode_select_third, mode_select_second, mode_select_first} <= ~s;
		@(posedge clk);
		#1;
		`CHK(mode_valid, 1'b1, "mode valid")
		`CHK(op_mode, exp_mode(s), "mode")
	endtask

	task automatic access(input vec_type v);
		@(posedge clk);
		access_valid <= 1'b1;
		addr <= v.addr;
		@(posedge clk);
		access_valid <= 1'b0;
		#1;
		`CHK(decode_valid, 1'b1, "decode valid")
		`CHK(hits, addr_map_pkg::region_hits_type'(v.hits), "hits")
		`CHK(low_region_select_n, ~v.hits[4], "low select")
		`CHK(high_region_select_n, ~v.hits[3], "high select")
		exp_lo += int'(v.hits[4]);
		exp_hi += int'(v.hits[3]);
		@(posedge clk);
		#1;
		`CHK(decode_valid, 1'b0, "idle valid")
		`CHK({low_region_select_n, high_region_select_n}, 2'h3, "idle selects")
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		forever #50 clk = ~clk;
	end

	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		wrap_up();
	end

	initial begin
		logic [3:0] cur;
		cur = 4'hF;
		foreach (vecs[i]) begin
			if (vecs[i].straps !== cur) begin
				cur = vecs[i].straps;
				do_reset(cur);
			end
			access(vecs[i]);
		end
		do_reset(4'h0);
		wrap_up();
	end
endmodule // tb

`default_nettype wire

// ==== src/address_map_decoder.sv ====
`timescale 1ns/10ps
`default_nettype none

module address_map_decoder #(
	parameter int ROM_KB = addr_map_pkg::ROM_KB_DEF
) (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Mode straps
	input  wire logic                          mode_select_first,
	input  wire logic                          mode_select_second,
	input  wire logic                          mode_select_third,
	input  wire logic                          flash_program_pin,
	// Access request
	input  wire logic                          access_valid,
	input  wire logic [addr_map_pkg::ADDR_W-1:0] addr,
	// Decode result
	output logic                               decode_valid,
	output addr_map_pkg::region_hits_type      hits,
	output logic                               low_region_select_n,
	output logic                               high_region_select_n,
	// Mode status
	output logic                               mode_valid,
	output addr_map_pkg::op_mode_type          op_mode
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (ROM_KB != 256 && ROM_KB != 384 && ROM_KB != 512) begin : g_bad_rom
		$error("address_map_decoder: ROM_KB must be 256, 384 or 512");
	end

	localparam logic [22:0] ROM_END = 23'((ROM_KB * 1024) - 1);
	localparam logic [22:0] RANGE_LO [3] = '{23'h0, addr_map_pkg::PERIPH_LO,
		addr_map_pkg::RAM_LO};
	localparam logic [22:0] RANGE_HI [3] = '{ROM_END, addr_map_pkg::PERIPH_HI,
		addr_map_pkg::RAM_HI};

	// ----------------------------------------
	// Mode capture
	// ----------------------------------------
	addr_map_pkg::op_mode_type mode_nxt;
	logic                      mode_valid_nxt;
	addr_map_pkg::op_mode_type pin_mode;

	always_comb begin
		case ({mode_select_first, mode_select_second, mode_select_third})
			3'h0:    pin_mode = addr_map_pkg::MODE_SINGLE;
			3'h2:    pin_mode = addr_map_pkg::MODE_EXTEND;
			3'h4:    pin_mode = flash_program_pin ? addr_map_pkg::MODE_RESERVED
				: addr_map_pkg::MODE_PROC;
			default: pin_mode = addr_map_pkg::MODE_RESERVED;
		endcase
	end

	always_comb begin
		mode_nxt       = op_mode;
		mode_valid_nxt = 1'b1;
		// Capture once on the first edge after release
		if (!mode_valid) begin
			mode_nxt = pin_mode;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_mode    <= addr_map_pkg::MODE_RESERVED;
			mode_valid <= 1'b0;
		end else begin
			op_mode    <= mode_nxt;
			mode_valid <= mode_valid_nxt;
		end
	end

	// ----------------------------------------
	// Range comparators
	// ----------------------------------------
	logic [22:0] cmp_val [3];
	logic [2:0]  range_hit;

	always_comb begin
		cmp_val[0] = addr[22:0];
		cmp_val[1] = {6'h00, addr[addr_map_pkg::WIN_W-1:0]};
		cmp_val[2] = {6'h00, addr[addr_map_pkg::WIN_W-1:0]};
	end

	for (genvar i = 0; i < 3; i++) begin : g_range
		region_match #(
			.W  (addr_map_pkg::CMP_W),
			.LO (RANGE_LO[i]),
			.HI (RANGE_HI[i])
		) u_match (
			.value (cmp_val[i]),
			.hit   (range_hit[i])
		);
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	addr_map_pkg::region_hits_type hits_nxt;
	logic                          decode_valid_nxt;
	logic                          low_sel_n_nxt;
	logic                          high_sel_n_nxt;
	logic                          in_low8m;
	logic                          in_high8m;
	logic                          ext_mode;

	always_comb begin
		hits_nxt         = addr_map_pkg::HITS_NONE;
		decode_valid_nxt = access_valid;
		in_low8m         = addr[31:23] == addr_map_pkg::LOW8M_TAG;
		in_high8m        = addr[31:23] == addr_map_pkg::HIGH8M_TAG;
		ext_mode         = (op_mode == addr_map_pkg::MODE_EXTEND)
			|| (op_mode == addr_map_pkg::MODE_PROC);
		if (access_valid) begin
			if (addr[31]) begin
				hits_nxt.system_space = 1'b1;
			end else if (in_low8m && mode_valid) begin
				// Placement depends on mode
				case (op_mode)
					addr_map_pkg::MODE_SINGLE: begin
						hits_nxt.rom = range_hit[0];
					end
					addr_map_pkg::MODE_EXTEND: begin
						hits_nxt.rom        = range_hit[0];
						hits_nxt.first_ext  = addr[22:20] == addr_map_pkg::CS0_EXT_MB;
						hits_nxt.second_ext = addr[22:21] == addr_map_pkg::CS1_2M;
					end
					addr_map_pkg::MODE_PROC: begin
						hits_nxt.first_ext  = addr[22:21] == addr_map_pkg::CS0_PROC_2M;
						hits_nxt.second_ext = addr[22:21] == addr_map_pkg::CS1_2M;
					end
					default: begin
						hits_nxt = addr_map_pkg::HITS_NONE;
					end
				endcase
			end else if (in_high8m) begin
				hits_nxt.periph = range_hit[1];
				hits_nxt.ram    = range_hit[2];
			end
			// Anything else in user space is unmapped
			hits_nxt.unmapped = !addr[31] && !hits_nxt.rom && !hits_nxt.first_ext
				&& !hits_nxt.second_ext && !hits_nxt.ram && !hits_nxt.periph;
		end
		low_sel_n_nxt  = !(hits_nxt.first_ext && ext_mode);
		high_sel_n_nxt = !(hits_nxt.second_ext && ext_mode);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			decode_valid         <= 1'b0;
			hits                 <= addr_map_pkg::HITS_NONE;
			low_region_select_n  <= 1'b1;
			high_region_select_n <= 1'b1;
		end else begin
			decode_valid         <= decode_valid_nxt;
			hits                 <= hits_nxt;
			low_region_select_n  <= low_sel_n_nxt;
			high_region_select_n <= high_sel_n_nxt;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_system_no_select: assert property (
		$past(access_valid) && $past(addr[31]) |->
			hits.system_space && low_region_select_n && high_region_select_n)
		else $error("system space access selected a region");

	a_single_no_ext: assert property (
		op_mode == addr_map_pkg::MODE_SINGLE && $past(op_mode) == addr_map_pkg::MODE_SINGLE
			|-> low_region_select_n && high_region_select_n)
		else $error("external select in single-chip mode");

	a_select_exclusive: assert property (
		!(!low_region_select_n && !high_region_select_n))
		else $error("both region selects asserted");

	a_first_ext_map: assert property (
		$past(access_valid) && $past(op_mode) == addr_map_pkg::MODE_EXTEND
			&& $past(addr[31:20]) == 12'h001 |-> !low_region_select_n)
		else $error("first region missed in extension mode");

	a_proc_ghost_map: assert property (
		$past(access_valid) && $past(op_mode) == addr_map_pkg::MODE_PROC
			&& $past(addr[31:21]) == 11'h000 |-> !low_region_select_n && !hits.rom)
		else $error("first region or ghost missed in processor mode");

	a_second_ghost: assert property (
		$past(access_valid) && $past(mode_valid) && $past(ext_mode)
			&& $past(addr[31:21]) == 11'h001 |-> !high_region_select_n)
		else $error("second region or ghost missed");

	a_ram_window: assert property (
		decode_valid |-> hits.ram == ($past(addr[31:23]) == 9'h001
			&& $past(addr[16:0]) >= 17'h04000 && $past(addr[16:0]) <= 17'h09FFF))
		else $error("ram decode wrong");

	a_periph_window: assert property (
		hits.periph |-> $past(addr[31:23]) == 9'h001 && $past(addr[16:14]) == 3'h0)
		else $error("peripheral window decode wrong");

	a_rom_end: assert property (
		hits.rom |-> $past(addr[31:23]) == 9'h000 && $past(addr[22:0]) <= ROM_END)
		else $error("rom hit beyond its end");

	a_mode_held: assert property (
		mode_valid && $past(mode_valid) |-> $stable(op_mode))
		else $error("mode changed after capture");

	a_unmapped_quiet: assert property (
		hits.unmapped || op_mode == addr_map_pkg::MODE_RESERVED
			|-> ##0 low_region_select_n && high_region_select_n)
		else $error("select asserted on unmapped access");

	c_first_select: cover property (!low_region_select_n);
	c_second_select: cover property (!high_region_select_n);
	c_ram_hit: cover property (hits.ram);
	c_system_hit: cover property (hits.system_space);

endmodule // address_map_decoder

`default_nettype wire

// ==== src/region_match.sv ====
`timescale 1ns/10ps
`default_nettype none

module region_match #(
	parameter int         W  = 23,
	parameter logic [W-1:0] LO = '0,
	parameter logic [W-1:0] HI = '1
) (
	// Compared value
	input  wire logic [W-1:0] value,
	// Result
	output logic              hit
);

	if (LO > HI) begin : g_bad_range
		$error("region_match: LO above HI");
	end

	always_comb begin
		hit = (value >= LO) && (value <= HI);
	end

endmodule // region_match

`default_nettype wire
